//--- logic/dpg_params.svh
// Purpose: register offsets, reset values and widths of the dual port gpio block
// Assumes: 12-bit apb byte address, one aligned 32-bit word per register
// Notes: included by bare name
`ifndef DPG_PARAMS_SVH
`define DPG_PARAMS_SVH
`define DPG_OFF_FP_DIR 12'h000
`define DPG_OFF_FP_LAT 12'h004
`define DPG_OFF_FP_VIEW 12'h008
`define DPG_OFF_FP_PCR 12'h00C
`define DPG_OFF_FP_ODR 12'h010
`define DPG_OFF_SP_DIR 12'h014
`define DPG_OFF_SP_LAT 12'h018
`define DPG_OFF_MUX 12'h01C
`define DPG_FP_W 4
`define DPG_MUX_W 9
`define DPG_RST_FP 4'h0
`define DPG_RST_SP 8'h00
`define DPG_RST_MUX 9'h000
`endif

//--- logic/dpg_pkg.sv
// Purpose: types of the dual port gpio block
// Assumes: nothing beyond the params header
// Notes: role codes follow gray order gpio_in, gpio_out, periph_out, periph_in
package dpg_pkg;
    typedef struct packed {
        logic transmitter_enable;
        logic receiver_enable;
        logic serial_sync_mode;
        logic serial_clock_out_en;
        logic serial_ext_clock_sel;
        logic [3:0] shutdown_in_enable;
    } dpg_mux_t;
    typedef struct packed {
        logic [3:0] pu;
        logic [3:0] oe;
        logic [3:0] o;
    } dpg_fp_drv_t;
    typedef enum logic [1:0] {
        DPG_ROLE_GPIO_IN = 2'h0,
        DPG_ROLE_GPIO_OUT = 2'h1,
        DPG_ROLE_PERIPH_OUT = 2'h3,
        DPG_ROLE_PERIPH_IN = 2'h2
    } dpg_role_t;
endpackage

//--- logic/dpg_top.sv
// Purpose: pin control for a 4-bit first port and an 8-bit second port behind apb
// Assumes: pins and peripheral signals are synchronous to pclk
// Notes: all pin and peripheral outputs are registered, one cycle after their cause
`timescale 1ns/1ps
`include "dpg_params.svh"
module dpg_top
    import dpg_pkg::*;
#(
    parameter int SP_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] fp_pin_in,
    output dpg_fp_drv_t fp_drv,
    output logic [SP_W-1:0] sp_pin_out,
    output logic [SP_W-1:0] sp_pin_oe,
    input wire logic serial_tx_data,
    input wire logic serial_clock_drive,
    output logic serial_rx_data,
    output logic serial_clock_in,
    output logic [3:0] shutdown_in
);

    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [3:0] fp_dir_ff;
    logic [3:0] fp_lat_ff;
    logic [3:0] fp_pcr_ff;
    logic [3:0] fp_odr_ff;
    logic [SP_W-1:0] sp_dir_ff;
    logic [SP_W-1:0] sp_lat_ff;
    dpg_mux_t mux_ff;
    dpg_fp_drv_t fp_drv_ff;
    logic serial_rx_ff;
    logic serial_clk_in_ff;
    logic [3:0] shutdown_ff;

    function automatic dpg_role_t pin_role(input int idx, input dpg_mux_t m, input logic dir);
        dpg_role_t r;
        r = dir ? DPG_ROLE_GPIO_OUT : DPG_ROLE_GPIO_IN;
        case (idx)
            3: begin
                if (m.serial_ext_clock_sel) begin
                    r = DPG_ROLE_PERIPH_IN;
                end else if (m.serial_sync_mode || m.serial_clock_out_en) begin
                    r = DPG_ROLE_PERIPH_OUT;
                end
            end
            2: begin
                if (m.receiver_enable) begin
                    r = DPG_ROLE_PERIPH_IN;
                end
            end
            1: begin
                if (m.transmitter_enable) begin
                    r = DPG_ROLE_PERIPH_OUT;
                end
            end
            default: begin
            end
        endcase
        if (m.shutdown_in_enable[idx]) begin
            r = DPG_ROLE_PERIPH_IN;
        end
        return r;
    endfunction

    // apb decode: read data captured in setup, write applied at the access edge
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pready_ff && pwrite;
    wire wr_lane0 = wr_acc && pstrb[0];
    wire hit_fp_dir = (paddr == `DPG_OFF_FP_DIR);
    wire hit_fp_lat = (paddr == `DPG_OFF_FP_LAT);
    wire hit_fp_view = (paddr == `DPG_OFF_FP_VIEW);
    wire hit_fp_pcr = (paddr == `DPG_OFF_FP_PCR);
    wire hit_fp_odr = (paddr == `DPG_OFF_FP_ODR);
    wire hit_sp_dir = (paddr == `DPG_OFF_SP_DIR);
    wire hit_sp_lat = (paddr == `DPG_OFF_SP_LAT);
    wire hit_mux = (paddr == `DPG_OFF_MUX);
    wire hit_any = hit_fp_dir || hit_fp_lat || hit_fp_view || hit_fp_pcr || hit_fp_odr
        || hit_sp_dir || hit_sp_lat || hit_mux;
    wire [3:0] fp_view = (fp_dir_ff & fp_lat_ff) | (~fp_dir_ff & fp_pin_in);
    // write-only and reserved bits read as zero
    wire [31:0] rd_val = hit_fp_lat ? {28'h0000000, fp_lat_ff} :
        hit_fp_view ? {28'h0000000, fp_view} :
        hit_fp_pcr ? {28'h0000000, fp_pcr_ff} :
        hit_fp_odr ? {28'h0000000, fp_odr_ff} :
        hit_sp_lat ? {{(32-SP_W){1'b0}}, sp_lat_ff} :
        hit_mux ? {23'h000000, mux_ff} : 32'h00000000;
    wire [8:0] nxt_mux = {pstrb[1] ? pwdata[8] : mux_ff[8],
        pstrb[0] ? pwdata[7:0] : mux_ff[7:0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !hit_any;
            prdata_ff <= (setup && !pwrite) ? rd_val : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fp_dir_ff <= `DPG_RST_FP;
            fp_lat_ff <= `DPG_RST_FP;
            fp_pcr_ff <= `DPG_RST_FP;
            fp_odr_ff <= `DPG_RST_FP;
            sp_dir_ff <= SP_W'(`DPG_RST_SP);
            sp_lat_ff <= SP_W'(`DPG_RST_SP);
            mux_ff <= `DPG_RST_MUX;
        end else begin
            if (wr_lane0 && hit_fp_dir) fp_dir_ff <= pwdata[3:0];
            if (wr_lane0 && hit_fp_lat) fp_lat_ff <= pwdata[3:0];
            if (wr_lane0 && hit_fp_pcr) fp_pcr_ff <= pwdata[3:0];
            if (wr_lane0 && hit_fp_odr) fp_odr_ff <= pwdata[3:0];
            if (wr_lane0 && hit_sp_dir) sp_dir_ff <= pwdata[SP_W-1:0];
            if (wr_lane0 && hit_sp_lat) sp_lat_ff <= pwdata[SP_W-1:0];
            if (wr_acc && hit_mux) mux_ff <= dpg_mux_t'(nxt_mux);
        end
    end

    // first-port pin multiplexer
    dpg_role_t role [4];
    wire [3:0] periph_val = {serial_clock_drive, 1'b0, serial_tx_data, 1'b0};
    logic [3:0] is_out;
    logic [3:0] out_val;
    dpg_fp_drv_t nxt_fp_drv;
    genvar gi;
    generate
        for (gi = 0; gi < `DPG_FP_W; gi++) begin : g_pin
            assign role[gi] = pin_role(gi, mux_ff, fp_dir_ff[gi]);
            assign is_out[gi] = (role[gi] == DPG_ROLE_GPIO_OUT)
                || (role[gi] == DPG_ROLE_PERIPH_OUT);
            assign out_val[gi] = (role[gi] == DPG_ROLE_PERIPH_OUT) ? periph_val[gi]
                : fp_lat_ff[gi];
            // open-drain drives only the low level
            assign nxt_fp_drv.oe[gi] = is_out[gi]
                && (!fp_odr_ff[gi] || !out_val[gi]);
            assign nxt_fp_drv.o[gi] = fp_odr_ff[gi] ? 1'b0 : out_val[gi];
            assign nxt_fp_drv.pu[gi] = !is_out[gi] && fp_pcr_ff[gi];
        end
    endgenerate
    wire rx_sel = mux_ff.receiver_enable && !mux_ff.shutdown_in_enable[2];
    wire ck_in_sel = mux_ff.serial_ext_clock_sel && !mux_ff.shutdown_in_enable[3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fp_drv_ff <= '0;
            serial_rx_ff <= 1'b1;
            serial_clk_in_ff <= 1'b0;
            shutdown_ff <= 4'h0;
        end else begin
            fp_drv_ff <= nxt_fp_drv;
            serial_rx_ff <= rx_sel ? fp_pin_in[2] : 1'b1;
            serial_clk_in_ff <= ck_in_sel ? fp_pin_in[3] : 1'b0;
            shutdown_ff <= mux_ff.shutdown_in_enable & fp_pin_in;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign fp_drv = fp_drv_ff;
    assign sp_pin_out = sp_lat_ff;
    assign sp_pin_oe = sp_dir_ff;
    assign serial_rx_data = serial_rx_ff;
    assign serial_clock_in = serial_clk_in_ff;
    assign shutdown_in = shutdown_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pullup_in;
        !mux_ff.shutdown_in_enable[0] && !fp_dir_ff[0] && fp_pcr_ff[0] |=> fp_drv.pu[0];
    endproperty
    a_pullup_in: assert property (p_pullup_in) else $error("pull-up missing");

    property p_reserved;
        setup && !pwrite && (hit_fp_pcr || hit_fp_odr) |=> prdata[31:4] == 28'h0000000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_open_drain;
        !mux_ff.shutdown_in_enable[0] && fp_dir_ff[0] && fp_odr_ff[0]
        |=> !fp_drv.pu[0] && !fp_drv.o[0] && fp_drv.oe[0] == !$past(fp_lat_ff[0]);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain wrong");

    property p_push_pull;
        !mux_ff.shutdown_in_enable[0] && fp_dir_ff[0] && !fp_odr_ff[0]
        |=> fp_drv.oe[0] && fp_drv.o[0] == $past(fp_lat_ff[0]);
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull wrong");

    property p_clk_out;
        !mux_ff.shutdown_in_enable[3] && !mux_ff.serial_ext_clock_sel && !fp_odr_ff[3]
        && mux_ff.serial_sync_mode |=> fp_drv.oe[3] && fp_drv.o[3] == $past(serial_clock_drive);
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock out wrong");

    property p_clk_in;
        mux_ff.serial_ext_clock_sel || mux_ff.shutdown_in_enable[3]
        |=> !fp_drv.oe[3] ##0 serial_clock_in == ($past(fp_pin_in[3]) && !shutdown_ff[3]
        && !$past(mux_ff.shutdown_in_enable[3]));
    endproperty
    a_clk_in: assert property (p_clk_in) else $error("pin 3 input wrong");

    property p_rx;
        rx_sel |=> !fp_drv.oe[2] && serial_rx_data == $past(fp_pin_in[2]);
    endproperty
    a_rx: assert property (p_rx) else $error("receive pin wrong");

    property p_tx;
        !mux_ff.shutdown_in_enable[1] && mux_ff.transmitter_enable && !fp_odr_ff[1]
        |=> fp_drv.oe[1] && fp_drv.o[1] == $past(serial_tx_data);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit pin wrong");

    property p_shutdown;
        mux_ff.shutdown_in_enable[0] |=> !fp_drv.oe[0] && shutdown_in[0] == $past(fp_pin_in[0]);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown pin wrong");

    property p_sp_dir;
        wr_lane0 && hit_sp_dir |=> sp_pin_oe == $past(pwdata[SP_W-1:0]);
    endproperty
    a_sp_dir: assert property (p_sp_dir) else $error("direction not applied");

    property p_sp_dir_wo;
        setup && !pwrite && hit_sp_dir |=> prdata == 32'h00000000 && pready;
    endproperty
    a_sp_dir_wo: assert property (p_sp_dir_wo) else $error("direction readable");

    property p_sp_lat;
        wr_lane0 && hit_sp_lat |=> sp_pin_out == $past(pwdata[SP_W-1:0]);
    endproperty
    a_sp_lat: assert property (p_sp_lat) else $error("latch not applied");

    property p_gpio2;
        !rx_sel && !mux_ff.shutdown_in_enable[2] && fp_dir_ff[2] && !fp_odr_ff[2]
        |=> fp_drv.oe[2] && fp_drv.o[2] == $past(fp_lat_ff[2]);
    endproperty
    a_gpio2: assert property (p_gpio2) else $error("gpio output wrong");

    property p_view;
        setup && !pwrite && hit_fp_view |=> prdata[3:0] == (($past(fp_dir_ff)
        & $past(fp_lat_ff)) | (~$past(fp_dir_ff) & $past(fp_pin_in)));
    endproperty
    a_view: assert property (p_view) else $error("pin view wrong");

    property p_unmapped;
        setup && !hit_any |=> pslverr && pready && prdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");

    property p_out_pu;
        is_out[0] |=> !fp_drv.pu[0];
    endproperty
    a_out_pu: assert property (p_out_pu) else $error("output pulled up");

    property p_rx_idle;
        !rx_sel |=> serial_rx_data;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("receive not idle");

    property p_ck_idle;
        !ck_in_sel |=> !serial_clock_in;
    endproperty
    a_ck_idle: assert property (p_ck_idle) else $error("clock input not idle");

    property p_tx_off;
        !mux_ff.shutdown_in_enable[1] && !mux_ff.transmitter_enable && !fp_dir_ff[1]
        |=> !fp_drv.oe[1];
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("pin 1 driven as input");

endmodule // dpg_top

//--- tb/dpg_board.sv
// Purpose: board side of the first port, resolving each pin level
// Assumes: the board drives a steady level on every pin the block releases
// Notes: a released pin with its pull-up on reads high
`timescale 1ns/1ps
module dpg_board
    import dpg_pkg::*;
(
    input wire logic [3:0] ext,
    input wire dpg_fp_drv_t drv,
    output logic [3:0] pin
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin[i] = drv.oe[i] ? drv.o[i] : (drv.pu[i] ? 1'b1 : ext[i]);
        end
    end
endmodule // dpg_board

//--- tb/dpg_tb.sv
// Purpose: self-checking bench of the dual port gpio block
// Assumes: zero-wait apb slave, outputs registered one cycle after their cause
// Notes: ext holds 4'hA on the board throughout
`timescale 1ns/1ps
`include "dpg_params.svh"
module dual_port_gpio_pin_control_test
    import dpg_pkg::*;
;
    typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r;} dpg_reg_row_t;
    typedef struct packed {
        logic [8:0] m; logic [3:0] oe; logic [3:0] o; logic [5:0] s;
    } dpg_pin_row_t;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, tx, ckd, pready, pslverr, er, rx, cki;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] ext, pins, sd;
    logic [7:0] spo, spe;
    dpg_fp_drv_t drv;
    int err_count = 0;
    int tests_run = 0;
    dpg_reg_row_t regs [7] = '{
        '{`DPG_OFF_FP_LAT, 32'h000000F5, 32'h5}, '{`DPG_OFF_FP_PCR, 32'h000000FF, 32'hF},
        '{`DPG_OFF_FP_ODR, 32'h000000F0, 32'h0}, '{`DPG_OFF_SP_LAT, 32'h000000A5, 32'hA5},
        '{`DPG_OFF_SP_DIR, 32'h0000003C, 32'h0}, '{`DPG_OFF_FP_DIR, 32'h00000003, 32'h0},
        '{`DPG_OFF_MUX, 32'h000001FF, 32'h1FF}};
    // with dir 3, latch 5, pulls and drains off, serial outputs high
    dpg_pin_row_t pinrows [7] = '{
        '{9'h00F, 4'h0, 4'h0, 6'h29}, '{9'h190, 4'h3, 4'h3, 6'h02}, '{9'h030, 4'h3, 4'h1, 6'h03},
        '{9'h020, 4'hB, 4'h9, 6'h01}, '{9'h040, 4'hB, 4'h9, 6'h01}, '{9'h018, 4'h3, 4'h1, 6'h21},
        '{9'h000, 4'h3, 4'h1, 6'h01}};
    always #5 pclk = ~pclk;
    dpg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fp_pin_in(pins), .fp_drv(drv), .sp_pin_out(spo),
        .sp_pin_oe(spe), .serial_tx_data(tx), .serial_clock_drive(ckd), .serial_rx_data(rx),
        .serial_clock_in(cki), .shutdown_in(sd));
    dpg_board i_board (.ext(ext), .drv(drv), .pin(pins));
    task end_of_test;
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            $display("[ERR] %0t no pready", $time);
            end_of_test;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext = 4'hA;
        tx = 1'b1;
        ckd = 1'b1;
        repeat (12) @(posedge pclk);
        chk({19'h0, rx, drv}, 32'h00001000);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, (i == 2) ? 32'hA : 32'h0);
        end
        foreach (regs[i]) begin
            apb(1'b1, regs[i].a, regs[i].w);
            apb(1'b0, regs[i].a, 32'h0);
            chk(rd, regs[i].r);
        end
        chk({spe, spo}, 32'h3CA5);
        apb(1'b1, `DPG_OFF_FP_PCR, 32'h0);
        foreach (pinrows[i]) begin
            apb(1'b1, `DPG_OFF_MUX, 32'(pinrows[i].m));
            repeat (2) @(posedge pclk);
            chk({drv.oe, drv.o & drv.oe, sd, cki, rx},
                32'(pinrows[i][13:0]));
        end
        // serial outputs low, so pins 3 and 1 must drive low, which their latch bits also hold
        tx <= 1'b0;
        ckd <= 1'b0;
        apb(1'b1, `DPG_OFF_MUX, 32'h120);
        repeat (2) @(posedge pclk);
        chk({drv.oe, drv.o & drv.oe}, 32'hB1);
        apb(1'b1, `DPG_OFF_MUX, 32'h0);
        apb(1'b1, `DPG_OFF_FP_PCR, 32'hF);
        repeat (2) @(posedge pclk);
        chk({drv.pu, drv.oe, drv.o & drv.oe}, 32'hC31);
        apb(1'b0, `DPG_OFF_FP_VIEW, 32'h0);
        chk(rd, 32'hD);
        apb(1'b1, `DPG_OFF_FP_ODR, 32'hF);
        repeat (2) @(posedge pclk);
        chk({drv.pu, drv.oe, drv.o}, 32'hC20);
        apb(1'b0, 12'h020, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({spe, spo, 4'h0, drv}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `DPG_OFF_SP_LAT, 32'h0);
        chk(rd, 32'h0);
        end_of_test;
    end
endmodule // dual_port_gpio_pin_control_test
